// ### rtl/acr_params.svh
// register offsets, field positions, reset values and timing counts
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// ****************************************************************
// register byte addresses on the bus
// ****************************************************************
`define ACR_OFS_INPUT_SELECT 4'h0
`define ACR_OFS_CONTROL_STATUS 4'h4
`define ACR_OFS_RESULT_LOW 4'h8
`define ACR_OFS_RESULT_HIGH 4'hc

// ****************************************************************
// input select fields
// ****************************************************************
`define ACR_REF_MSB 7
`define ACR_REF_LSB 6
`define ACR_LEFT_ADJ_BIT 5
`define ACR_CHAN_MSB 3
`define ACR_CHAN_LSB 0

// ****************************************************************
// control and status fields
// ****************************************************************
`define ACR_ENABLE_BIT 7
`define ACR_START_BIT 6
`define ACR_FREE_RUN_BIT 5
`define ACR_FLAG_BIT 4
`define ACR_IRQ_EN_BIT 3
`define ACR_PRESC_MSB 2
`define ACR_PRESC_LSB 0

// ****************************************************************
// reset values and cycle counts
// ****************************************************************
`define ACR_INPUT_SELECT_RESET 8'h00
`define ACR_CONTROL_RESET 8'h00
`define ACR_RESULT_RESET 10'h000
`define ACR_FIRST_CONV_CYCLES 5'd25
`define ACR_NORMAL_CONV_CYCLES 5'd13
`define ACR_RESULT_MAX 10'h3ff

`endif

// ### rtl/acr_pkg.sv
// types shared by the converter control block
package acr_pkg;

    // ************************************************************
    // conversion sequencer states
    // ************************************************************
    typedef enum logic [1:0] {
        ACR_IDLE,
        ACR_CONVERT,
        ACR_FINISH
    } acr_state_t;

    typedef logic [9:0] acr_code_t;

endpackage : acr_pkg

// ### rtl/acr_prescaler.sv
// converter clock prescaler: one-cycle tick every divisor system clocks
`timescale 1ns/10ps
`default_nettype none
`include "acr_params.svh"

module acr_prescaler #(
    parameter int CNT_W = 7
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic run,
    input wire logic [2:0] prescaler_select,
    output logic tick
);
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [CNT_W-1:0] last_count;
    logic at_last;

    // divisor minus one; codes 0 and 1 both divide by two
    function automatic logic [CNT_W-1:0] last_of(input logic [2:0] code);
        logic [CNT_W-1:0] one;
        one = {{(CNT_W-1){1'b0}}, 1'b1};
        if (code == 3'h0) begin
            last_of = one;
        end else begin
            last_of = (one << code) - one;
        end
    endfunction : last_of

    assign last_count = last_of(prescaler_select);
    assign at_last = (count_reg >= last_count);
    // stopped counter restarts at zero so cycle counts repeat exactly
    assign count_next = (!run || at_last) ? '0 : count_reg + 1'b1;

    // ************************************************************
    // counter and tick
    // ************************************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count_reg <= '0;
            tick <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick <= run && at_last;
        end
    end

endmodule : acr_prescaler
`default_nettype wire

// ### rtl/acr_control.sv
// converter control, result registers and wishbone slave
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "acr_params.svh"

// ****************************************************************
// converter control top
// ****************************************************************

// Functional notes
// - result is unsigned 10-bit ratio code
// - result readable once complete flag sets
// - reference select codes drive reference outputs
// - reference and channel latched per conversion
// - channel codes route inputs, bandgap, ground
// - left adjust changes presentation immediately
// - right or left byte packing of result
// - enable powers converter, clearing aborts conversion
// - start bit begins conversions
// - first conversion 25 cycles, others 13
// - start reads one while busy
// - free running converts continuously
// - flag sets when conversion completes
// - irq when flag, enable, global enable
// - flag cleared by vector or writing one
// - prescaler divides system clock by 2..128
// - low byte read locks result until high
// - free running restarts with newly latched settings
module acr_control (
    input wire logic sys_clk,
    input wire logic reset,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // cpu interrupt side
    input wire logic global_irq_enable,
    input wire logic irq_vector_taken,
    output logic conversion_irq,
    // analog array side
    input wire logic [9:0] array_code,
    output logic array_power,
    output logic array_sample,
    output logic [1:0] reference_select,
    output logic [3:0] channel_select,
    output logic [7:0] channel_route,
    output logic bandgap_route,
    output logic ground_route
);
    import acr_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    acr_state_t state_reg;
    acr_state_t state_next;
    logic [7:0] input_select_reg;
    logic enable_reg;
    logic start_reg;
    logic free_run_reg;
    logic flag_reg;
    logic irq_en_reg;
    logic [2:0] presc_reg;
    acr_code_t result_reg;
    logic lock_reg;
    logic first_reg;
    logic [4:0] cyc_reg;
    logic [4:0] cyc_next;
    logic [1:0] ref_reg;
    logic [3:0] chan_reg;
    logic [7:0] route_reg;
    logic bandgap_reg;
    logic ground_reg;
    logic power_reg;
    logic sample_reg;
    logic irq_reg;
    logic ack_reg;
    logic err_reg;
    logic [31:0] rdata_reg;
    acr_code_t array_sync1_reg;
    acr_code_t array_sync2_reg;
    logic tick;

    // ************************************************************
    // bus decode
    // ************************************************************
    wire logic bus_req;
    wire logic wr_lane0;
    wire logic hit_sel;
    wire logic hit_ctl;
    wire logic hit_lo;
    wire logic hit_hi;
    wire logic mapped;
    wire logic wr_sel;
    wire logic wr_ctl;
    wire logic rd_lo;
    wire logic rd_hi;

    // one access per request; ack drops the cycle after it rises
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
    assign wr_lane0 = wb_we_i && wb_sel_i[0];
    assign hit_sel = (wb_adr_i == `ACR_OFS_INPUT_SELECT);
    assign hit_ctl = (wb_adr_i == `ACR_OFS_CONTROL_STATUS);
    assign hit_lo = (wb_adr_i == `ACR_OFS_RESULT_LOW);
    assign hit_hi = (wb_adr_i == `ACR_OFS_RESULT_HIGH);
    assign mapped = hit_sel || hit_ctl || hit_lo || hit_hi;
    assign wr_sel = bus_req && hit_sel && wr_lane0;
    assign wr_ctl = bus_req && hit_ctl && wr_lane0;
    assign rd_lo = bus_req && hit_lo && !wb_we_i && wb_sel_i[0];
    assign rd_hi = bus_req && hit_hi && !wb_we_i && wb_sel_i[0];

    // ************************************************************
    // control write decode
    // ************************************************************
    wire logic [7:0] wd;
    wire logic enable_next;
    wire logic start_req;
    wire logic abort;
    wire logic begin_first;
    wire logic done;
    wire logic auto_restart;
    wire logic flag_clear;
    wire logic result_load;

    assign wd = wb_dat_i[7:0];
    assign enable_next = wr_ctl ? wd[`ACR_ENABLE_BIT] : enable_reg;
    // a zero written to start is ignored
    assign start_req = wr_ctl && wd[`ACR_START_BIT] && enable_next;
    assign abort = enable_reg && !enable_next;
    // first conversion after enabling carries initialization
    assign begin_first = first_reg || (wr_ctl && wd[`ACR_ENABLE_BIT]
        && !enable_reg);
    assign done = (state_reg == ACR_FINISH);
    assign auto_restart = done && free_run_reg && enable_next;
    // writing one or vector taken clears; a completing event wins
    assign flag_clear = irq_vector_taken
        || (wr_ctl && wd[`ACR_FLAG_BIT]);
    // new result is dropped while the low byte read holds the lock
    assign result_load = done && !lock_reg && !rd_hi;

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        cyc_next = cyc_reg;
        unique case (state_reg)
            ACR_IDLE: begin
                if (start_req) begin
                    state_next = ACR_CONVERT;
                    cyc_next = begin_first ? `ACR_FIRST_CONV_CYCLES
                        : `ACR_NORMAL_CONV_CYCLES;
                end
            end
            ACR_CONVERT: begin
                if (tick) begin
                    cyc_next = cyc_reg - 5'd1;
                    if (cyc_reg == 5'd1) begin
                        state_next = ACR_FINISH;
                    end
                end
            end
            ACR_FINISH: begin
                if (auto_restart) begin
                    state_next = ACR_CONVERT;
                    cyc_next = `ACR_NORMAL_CONV_CYCLES;
                end else begin
                    state_next = ACR_IDLE;
                end
            end
        endcase
        if (abort) begin
            state_next = ACR_IDLE;
            cyc_next = 5'd0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= ACR_IDLE;
            cyc_reg <= 5'd0;
        end else begin
            state_reg <= state_next;
            cyc_reg <= cyc_next;
        end
    end

    // ************************************************************
    // prescaler, running only while enabled
    // ************************************************************
    acr_prescaler #(
        .CNT_W(7)
    ) u_presc (
        .sys_clk(sys_clk),
        .reset(reset),
        .run(enable_reg && (state_reg == ACR_CONVERT)),
        .prescaler_select(presc_reg),
        .tick(tick)
    );

    // ************************************************************
    // register file
    // ************************************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            input_select_reg <= `ACR_INPUT_SELECT_RESET;
            enable_reg <= 1'b0;
            free_run_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            presc_reg <= 3'h0;
        end else begin
            if (wr_sel) begin
                input_select_reg <= wd;
            end
            if (wr_ctl) begin
                enable_reg <= wd[`ACR_ENABLE_BIT];
                free_run_reg <= wd[`ACR_FREE_RUN_BIT];
                irq_en_reg <= wd[`ACR_IRQ_EN_BIT];
                presc_reg <= wd[`ACR_PRESC_MSB:`ACR_PRESC_LSB];
            end
        end
    end

    // ************************************************************
    // start, flag, first-conversion and lock state
    // ************************************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            start_reg <= 1'b0;
            flag_reg <= 1'b0;
            first_reg <= 1'b0;
            lock_reg <= 1'b0;
        end else begin
            // start reads one exactly while a conversion runs
            start_reg <= (state_next == ACR_CONVERT);
            if (done) begin
                flag_reg <= 1'b1;
            end else if (flag_clear) begin
                flag_reg <= 1'b0;
            end
            if (abort || !enable_next) begin
                first_reg <= 1'b0;
            end else if (wr_ctl && wd[`ACR_ENABLE_BIT] && !enable_reg) begin
                first_reg <= !start_req;
            end else if (start_req) begin
                first_reg <= 1'b0;
            end
            if (rd_hi) begin
                lock_reg <= 1'b0;
            end else if (rd_lo) begin
                lock_reg <= 1'b1;
            end
        end
    end

    // ************************************************************
    // settings latch and analog routing
    // ************************************************************
    // settings captured only when a conversion begins
    wire logic latch_now;
    assign latch_now = (start_req && state_reg == ACR_IDLE)
        || auto_restart;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ref_reg <= 2'h0;
            chan_reg <= 4'h0;
            route_reg <= 8'h00;
            bandgap_reg <= 1'b0;
            ground_reg <= 1'b0;
        end else if (latch_now) begin
            ref_reg <= input_select_reg[`ACR_REF_MSB:`ACR_REF_LSB];
            chan_reg <= input_select_reg[`ACR_CHAN_MSB:`ACR_CHAN_LSB];
            // codes 8..13 leave every switch open
            route_reg <= input_select_reg[3] ? 8'h00
                : 8'h01 << input_select_reg[2:0];
            bandgap_reg <= (input_select_reg[3:0] == 4'he);
            ground_reg <= (input_select_reg[3:0] == 4'hf);
        end
    end

    // ************************************************************
    // result capture from the array, two-stage synchronised
    // ************************************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            array_sync1_reg <= `ACR_RESULT_RESET;
            array_sync2_reg <= `ACR_RESULT_RESET;
            result_reg <= `ACR_RESULT_RESET;
        end else begin
            array_sync1_reg <= array_code;
            array_sync2_reg <= array_sync1_reg;
            // code 0 is ground, full scale is reference less one step
            if (result_load) begin
                result_reg <= array_sync2_reg & `ACR_RESULT_MAX;
            end
        end
    end

    // ************************************************************
    // read data: left adjust applies to the stored result at once
    // ************************************************************
    wire logic adj;
    wire logic [7:0] res_lo;
    wire logic [7:0] res_hi;
    wire logic [7:0] ctl_view;
    wire logic [7:0] rd_byte;

    assign adj = input_select_reg[`ACR_LEFT_ADJ_BIT];
    assign res_lo = adj ? {result_reg[1:0], 6'h00} : result_reg[7:0];
    assign res_hi = adj ? result_reg[9:2] : {6'h00, result_reg[9:8]};
    assign ctl_view = {enable_reg, start_reg, free_run_reg, flag_reg,
        irq_en_reg, presc_reg};
    assign rd_byte = hit_sel ? input_select_reg
        : hit_ctl ? ctl_view
        : hit_lo ? res_lo
        : hit_hi ? res_hi : 8'h00;

    // ************************************************************
    // bus answer and outputs, all registered
    // ************************************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            power_reg <= 1'b0;
            sample_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req && mapped;
            err_reg <= bus_req && !mapped; // unmapped answers with err
            rdata_reg <= {24'h00_0000, rd_byte};
            power_reg <= enable_next;
            sample_reg <= latch_now;
            irq_reg <= flag_reg && irq_en_reg && global_irq_enable;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = rdata_reg;
    assign conversion_irq = irq_reg;
    assign array_power = power_reg;
    assign array_sample = sample_reg;
    assign reference_select = ref_reg;
    assign channel_select = chan_reg;
    assign channel_route = route_reg;
    assign bandgap_route = bandgap_reg;
    assign ground_route = ground_reg;

endmodule : acr_control
`default_nettype wire

// ### bench/acr_control_asserts.sv
// port assertions for the converter control block
`timescale 1ns/10ps
`default_nettype none

module acr_control_chk (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic global_irq_enable,
    input wire logic conversion_irq,
    input wire logic array_power,
    input wire logic array_sample,
    input wire logic [1:0] reference_select,
    input wire logic [3:0] channel_select,
    input wire logic [7:0] channel_route,
    input wire logic bandgap_route,
    input wire logic ground_route
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    logic [11:0] gap_reg;

    // cycles since the last sample pulse, saturating; zero means none yet
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            gap_reg <= 12'h000;
        end else if (array_sample) begin
            gap_reg <= 12'h001;
        end else if (gap_reg != 12'h000 && gap_reg != 12'hfff) begin
            gap_reg <= gap_reg + 12'h001;
        end
    end

    chk_bus_take_answer:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
            |=> wb_ack_o || wb_err_o)
        else $error("bus request not answered next cycle");
    chk_bus_answer_pulse:
        assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
        else $error("bus answer longer than one cycle");
    chk_bus_answer_cause:
        assert property (wb_ack_o || wb_err_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("bus answer without request");
    chk_irq_global_gate:
        assert property (conversion_irq |-> $past(global_irq_enable))
        else $error("interrupt raised while globally disabled");
    chk_sample_needs_power:
        assert property (array_sample |-> array_power)
        else $error("conversion began with array unpowered");
    chk_route_decode:
        assert property (array_sample |=> (channel_route == ((channel_select
            < 4'h8) ? (8'h01 << channel_select[2:0]) : 8'h00))
            && bandgap_route == (channel_select == 4'he)
            && ground_route == (channel_select == 4'hf))
        else $error("channel routing does not match channel code");
    chk_settings_held:
        assert property (!$stable({reference_select, channel_select})
            |-> array_sample || $past(array_sample))
        else $error("settings changed inside a conversion");
    chk_sample_gap:
        assert property (array_sample && gap_reg != 12'h000
            |-> gap_reg >= 12'd26)
        else $error("conversions closer than thirteen ticks");
endmodule : acr_control_chk

bind acr_control acr_control_chk acr_control_chk_inst (
    .sys_clk(sys_clk),
    .reset(reset),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o),
    .global_irq_enable(global_irq_enable),
    .conversion_irq(conversion_irq),
    .array_power(array_power),
    .array_sample(array_sample),
    .reference_select(reference_select),
    .channel_select(channel_select),
    .channel_route(channel_route),
    .bandgap_route(bandgap_route),
    .ground_route(ground_route)
);

`default_nettype wire

// ### bench/acr_array_model.sv
// behavioural analog array: code set by the latched channel
`timescale 1ns/10ps
`default_nettype none

module acr_array_model (
    input wire logic sys_clk,
    input wire logic array_power,
    input wire logic [3:0] channel_select,
    output logic [9:0] array_code
);
    logic [9:0] junk_reg = 10'h155;

    // unpowered array gives no stable code, so toggle garbage
    always @(posedge sys_clk) begin
        junk_reg <= ~junk_reg;
    end

    // ground reads 0x000, bandgap full scale, others a channel pattern
    assign array_code = !array_power ? junk_reg :
        (channel_select == 4'hf) ? 10'h000 :
        (channel_select == 4'he) ? 10'h3ff : {channel_select, 6'h2d};
endmodule : acr_array_model

`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
`include "acr_params.svh"

module tb;
    localparam logic [3:0] ofs_sel = `ACR_OFS_INPUT_SELECT;
    localparam logic [3:0] ofs_ctl = `ACR_OFS_CONTROL_STATUS;
    localparam logic [3:0] ofs_lo = `ACR_OFS_RESULT_LOW;
    localparam logic [3:0] ofs_hi = `ACR_OFS_RESULT_HIGH;
    logic sys_clk;
    logic reset = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic gie = 1'b1;
    logic vec = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, wb_err_o, conversion_irq, array_power, array_sample;
    logic bandgap_route, ground_route, bus_err;
    logic [9:0] array_code;
    logic [1:0] reference_select;
    logic [3:0] channel_select;
    logic [7:0] channel_route;
    int num_errors = 0;
    int checks_done = 0;

    acr_control acr_control_inst (
        .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .global_irq_enable(gie), .irq_vector_taken(vec),
        .conversion_irq(conversion_irq), .array_code(array_code),
        .array_power(array_power), .array_sample(array_sample),
        .reference_select(reference_select),
        .channel_select(channel_select), .channel_route(channel_route),
        .bandgap_route(bandgap_route), .ground_route(ground_route)
    );
    acr_array_model acr_array_model_inst (
        .sys_clk(sys_clk), .array_power(array_power),
        .channel_select(channel_select), .array_code(array_code)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    // classic single cycle, held until the edge that sees ack or err
    task automatic wb_xfer(input logic wr, input logic [3:0] adr,
                           input logic [7:0] wd, output logic [7:0] rd);
        int n;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= wr;
        wb_sel_i <= 4'h1;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h000000, wd};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 200);
        // a bus that never answers ends the run as a failure
        if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
            num_errors++;
            results();
        end
        rd = wb_dat_o[7:0];
        bus_err = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_sel_i <= 4'h0;
    endtask : wb_xfer

    task automatic wr(input logic [3:0] adr, input logic [7:0] d);
        logic [7:0] junk;
        wb_xfer(1'b1, adr, d, junk);
    endtask : wr

    task automatic rdchk(input logic [3:0] adr, input logic [7:0] exp);
        logic [7:0] v;
        wb_xfer(1'b0, adr, 8'h00, v);
        check(v, exp);
    endtask : rdchk

    // two edges first so a just-cleared flag has left the irq line
    task automatic wait_irq(output int n);
        n = 0;
        @(posedge sys_clk);
        do begin
            @(posedge sys_clk);
            n++;
        end while (conversion_irq !== 1'b1 && n < 5000);
        if (conversion_irq !== 1'b1) begin
            num_errors++;
            results();
        end
    endtask : wait_irq

    // start by control write, time sample pulse to interrupt
    task automatic conv(input logic [7:0] ctl, input int ticks, input int div);
        int n;
        wr(ofs_ctl, ctl);
        n = 0;
        while (array_sample !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        wait_irq(n);
        check(n >= ticks * div - div && n <= ticks * div + 5, 1'b1);
    endtask : conv

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial begin
        #100000;
        num_errors++;
        results();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        logic [7:0] v;
        int n;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        rdchk(ofs_sel, 8'h00);
        rdchk(ofs_ctl, 8'h00);
        rdchk(ofs_lo, 8'h00);
        rdchk(ofs_hi, 8'h00);
        wb_xfer(1'b0, 4'h2, 8'h00, v);
        check(bus_err, 1'b1);
        // enable and start in one write: the long first conversion
        wr(ofs_sel, 8'h45);
        conv(8'hc8, 25, 2);
        rdchk(ofs_ctl, 8'h98);
        check(reference_select, 2'b01);
        check(channel_route, 8'h20);
        gie <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check(conversion_irq, 1'b0);
        gie <= 1'b1;
        rdchk(ofs_lo, 8'h6d);
        rdchk(ofs_hi, 8'h01);
        wr(ofs_sel, 8'h65);
        rdchk(ofs_lo, 8'h40);
        rdchk(ofs_hi, 8'h5b);
        // zero leaves the flag, one clears it
        wr(ofs_ctl, 8'h88);
        rdchk(ofs_ctl, 8'h98);
        wr(ofs_ctl, 8'h98);
        rdchk(ofs_ctl, 8'h88);
        // every divisor code, flag cleared by the vector each time
        for (int c = 0; c < 8; c++) begin
            conv({5'h1b, c[2:0]}, 13, (c < 2) ? 2 : (1 << c));
            vec <= 1'b1;
            @(posedge sys_clk);
            vec <= 1'b0;
            repeat (2) @(posedge sys_clk);
            check(conversion_irq, 1'b0);
        end
        // low read locks; a result arriving then is dropped
        wr(ofs_sel, 8'h0f);
        conv(8'hd8, 13, 2);
        check(ground_route, 1'b1);
        rdchk(ofs_lo, 8'h00);
        wr(ofs_sel, 8'h0e);
        conv(8'hd8, 13, 2);
        check(bandgap_route, 1'b1);
        rdchk(ofs_hi, 8'h00);
        rdchk(ofs_lo, 8'h00);
        rdchk(ofs_hi, 8'h00);
        conv(8'hd8, 13, 2);
        rdchk(ofs_lo, 8'hff);
        rdchk(ofs_hi, 8'h03);
        // free running: a channel change hits the conversion after next
        wr(ofs_sel, 8'h01);
        conv(8'hf8, 13, 2);
        wr(ofs_sel, 8'h02);
        wr(ofs_ctl, 8'hb8);
        wait_irq(n);
        rdchk(ofs_lo, 8'h6d);
        rdchk(ofs_hi, 8'h00);
        wr(ofs_ctl, 8'hb8);
        wait_irq(n);
        rdchk(ofs_lo, 8'had);
        rdchk(ofs_hi, 8'h00);
        // disabling mid-run aborts and stops the free run
        wr(ofs_ctl, 8'h18);
        repeat (2) @(posedge sys_clk);
        check(array_power, 1'b0);
        rdchk(ofs_ctl, 8'h08);
        n = 0;
        repeat (100) begin
            @(posedge sys_clk);
            if (array_sample === 1'b1) n++;
        end
        check(n, 0);
        // enable alone, then start: still the long first conversion
        wr(ofs_ctl, 8'h80);
        conv(8'hc8, 25, 2);
        results();
    end
endmodule : tb

`default_nettype wire
